// [hw/dws_pkg.sv]
// Shared constants and types of the two-channel waveform sequencer
package dws_pkg;

    // Clocking: system clock and derived base tick rate
    localparam int unsigned SYS_CLK_HZ    = 100_000_000;
    localparam int unsigned BASE_TICK_HZ  = 40_000_000;
    localparam int unsigned MAX_UPDATE_HZ = 1_000_000;
    localparam int unsigned MIN_UI_COUNT  = BASE_TICK_HZ / MAX_UPDATE_HZ;

    // Widths and sizes
    localparam int unsigned CODE_W_DEF     = 12;
    localparam int unsigned CNT_W          = 24;
    localparam int unsigned DLY_W          = 16;
    localparam int unsigned FIFO_DEPTH_DEF = 1024;
    localparam int unsigned CTRL_W         = 13;
    localparam int unsigned NUM_CH         = 2;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_CMD    = 6'h04;
    localparam logic [5:0] OFS_STATUS = 6'h08;
    localparam logic [5:0] OFS_UI     = 6'h0C;
    localparam logic [5:0] OFS_UC     = 6'h10;
    localparam logic [5:0] OFS_IC     = 6'h14;
    localparam logic [5:0] OFS_DLY1   = 6'h18;
    localparam logic [5:0] OFS_DLY2   = 6'h1C;
    localparam logic [5:0] OFS_SW0    = 6'h20;
    localparam logic [5:0] OFS_SW1    = 6'h24;
    localparam logic [5:0] OFS_FIFO   = 6'h28;

    // Control register fields
    localparam int unsigned F_TIMED     = 0;
    localparam int unsigned F_BIPOLAR   = 2;
    localparam int unsigned F_EXTREF    = 4;
    localparam int unsigned F_DELAY     = 6;
    localparam int unsigned F_RETRIG    = 7;
    localparam int unsigned F_INFINITE  = 8;
    localparam int unsigned F_DLY1_UNIT = 9;
    localparam int unsigned F_DLY2_UNIT = 10;
    localparam int unsigned F_STOP      = 11;

    // Command register bits
    localparam int unsigned C_ARM   = 0;
    localparam int unsigned C_TRIG  = 1;
    localparam int unsigned C_STOP  = 2;
    localparam int unsigned C_CLEAR = 3;

    // Status register fields
    localparam int unsigned S_BUSY  = 0;
    localparam int unsigned S_EMPTY = 2;
    localparam int unsigned S_FULL  = 3;
    localparam int unsigned S_UNDER = 4;
    localparam int unsigned S_ARMED = 5;
    localparam int unsigned S_LEVEL = 16;

    // Stop modes
    localparam logic [1:0] STOP_NOW  = 2'h1;
    localparam logic [1:0] STOP_WAVE = 2'h2;
    localparam logic [1:0] STOP_ITER = 2'h3;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
    localparam logic [CNT_W-1:0]  UI_RST   = 24'h000028;
    localparam logic [CNT_W-1:0]  UC_RST   = 24'h000001;
    localparam logic [CNT_W-1:0]  IC_RST   = 24'h000001;
    localparam logic [DLY_W-1:0]  DLY_RST  = 16'h0000;
    localparam logic [11:0]       CODE_RST = 12'h000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DLY1,
        ST_RUN,
        ST_DLY2
    } dws_state_e;

endpackage : dws_pkg

// [hw/dws_top.sv]
// Two-channel waveform sequencer with Avalon-MM register slave
`timescale 1ns/1ps
module dws_top
    import dws_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int unsigned CODE_W     = CODE_W_DEF
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic [5:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              trigger_in,
    output logic      [CODE_W-1:0] dac_code0,
    output logic      [CODE_W-1:0] dac_code1,
    output logic      [1:0]        output_write_strobe,
    output logic      [1:0]        dac_bipolar,
    output logic      [1:0]        external_reference_input,
    output logic      [1:0]        dac_busy,
    output logic                   dma_refill_req
);

    localparam int unsigned AW = $clog2(FIFO_DEPTH);

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : merge_be

    // Register bus decode
    logic              rd_ack_r;
    logic [31:0]       readdata_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [CNT_W-1:0]  ui_r;
    logic [CNT_W-1:0]  uc_r;
    logic [CNT_W-1:0]  ic_r;
    logic [DLY_W-1:0]  dly1_r;
    logic [DLY_W-1:0]  dly2_r;
    logic [AW:0]       level_r;
    logic              fifo_full;

    wire sel_ctrl = avs_address == OFS_CTRL;
    wire sel_cmd  = avs_address == OFS_CMD;
    wire sel_stat = avs_address == OFS_STATUS;
    wire sel_ui   = avs_address == OFS_UI;
    wire sel_uc   = avs_address == OFS_UC;
    wire sel_ic   = avs_address == OFS_IC;
    wire sel_dly1 = avs_address == OFS_DLY1;
    wire sel_dly2 = avs_address == OFS_DLY2;
    wire sel_sw0  = avs_address == OFS_SW0;
    wire sel_sw1  = avs_address == OFS_SW1;
    wire sel_fifo = avs_address == OFS_FIFO;

    // Reads take one wait state; FIFO writes stall while full
    assign avs_waitrequest = (avs_read & ~rd_ack_r)
                           | (avs_write & sel_fifo & fifo_full);
    assign avs_readdata    = readdata_r;
    wire wr_go = avs_write & ~avs_waitrequest;
    wire [31:0] wd = avs_writedata;
    wire [31:0] wd_cmd = wd & merge_be(32'h0, 32'hFFFFFFFF, avs_byteenable);

    wire cmd_go    = wr_go & sel_cmd;
    wire cmd_arm   = cmd_go & wd_cmd[C_ARM];
    wire cmd_trig  = cmd_go & wd_cmd[C_TRIG];
    wire cmd_stop  = cmd_go & wd_cmd[C_STOP];
    wire cmd_clear = cmd_go & wd_cmd[C_CLEAR];

    // Control fields
    wire [1:0] timed      = ctrl_r[F_TIMED +: 2];
    wire       delay_mode = ctrl_r[F_DELAY];
    wire       retrig     = ctrl_r[F_RETRIG];
    wire       infinite   = ctrl_r[F_INFINITE];
    wire       dly1_per   = ctrl_r[F_DLY1_UNIT];
    wire       dly2_per   = ctrl_r[F_DLY2_UNIT];
    wire [1:0] stop_mode  = ctrl_r[F_STOP +: 2];

    assign dac_bipolar              = ctrl_r[F_BIPOLAR +: 2];
    assign external_reference_input = ctrl_r[F_EXTREF +: 2];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RST;
            ui_r   <= UI_RST;
            uc_r   <= UC_RST;
            ic_r   <= IC_RST;
            dly1_r <= DLY_RST;
            dly2_r <= DLY_RST;
        end else if (wr_go) begin
            if (sel_ctrl)
                ctrl_r <= CTRL_W'(merge_be(32'(ctrl_r), wd, avs_byteenable));
            if (sel_ui)
                ui_r <= CNT_W'(merge_be(32'(ui_r), wd, avs_byteenable));
            if (sel_uc)
                uc_r <= CNT_W'(merge_be(32'(uc_r), wd, avs_byteenable));
            if (sel_ic)
                ic_r <= CNT_W'(merge_be(32'(ic_r), wd, avs_byteenable));
            if (sel_dly1)
                dly1_r <= DLY_W'(merge_be(32'(dly1_r), wd, avs_byteenable));
            if (sel_dly2)
                dly2_r <= DLY_W'(merge_be(32'(dly2_r), wd, avs_byteenable));
        end
    end

    // Base tick: fractional divide of the system clock
    logic [27:0] tb_acc_r;
    wire  [28:0] tb_sum    = {1'b0, tb_acc_r} + 29'(BASE_TICK_HZ);
    wire         base_tick = tb_sum >= 29'(SYS_CLK_HZ);

    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            tb_acc_r <= 28'h0000000;
        else
            tb_acc_r <= base_tick ? 28'(tb_sum - 29'(SYS_CLK_HZ))
                                  : 28'(tb_sum);
    end

    // Generation engine
    dws_state_e       gen_st_r;
    dws_state_e       gen_nxt;
    logic             armed_r;
    logic             stop_pend_r;
    logic             replay_r;
    logic             underrun_r;
    logic [1:0]       run_ch_r;
    logic [CNT_W-1:0] ui_cnt_r;
    logic [CNT_W-1:0] uc_cnt_r;
    logic [CNT_W-1:0] it_cnt_r;
    logic [DLY_W-1:0] dly_cnt_r;
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    base_ptr_r;

    wire       active   = gen_st_r != ST_IDLE;
    wire [1:0] ch_en    = active ? run_ch_r : timed;
    wire [1:0] n_ch     = {1'b0, ch_en[0]} + {1'b0, ch_en[1]};
    wire       per_tick = active & base_tick & (ui_cnt_r == '0);
    wire       trig_any = trigger_in | cmd_trig;
    wire       start_ok = armed_r & ~active & (|timed) & trig_any;
    wire       use_dly1 = delay_mode & (dly1_r != '0);
    wire       upd_tick = (gen_st_r == ST_RUN) & per_tick;
    wire       have_data = level_r >= {{(AW-1){1'b0}}, n_ch};
    wire       wave_end  = upd_tick & ({1'b0, uc_cnt_r} + 25'h1 >= {1'b0, uc_r});
    wire       group_end = {1'b0, it_cnt_r} + 25'h1 >= {1'b0, ic_r};
    wire       stop_req  = stop_pend_r | (cmd_stop & active);
    wire       halt_now  = cmd_stop & active & (stop_mode != STOP_WAVE)
                         & (stop_mode != STOP_ITER);
    wire       halt_wave = (~infinite & group_end)
                         | (stop_req & (stop_mode == STOP_WAVE))
                         | (stop_req & (stop_mode == STOP_ITER) & group_end);
    wire       unit_per  = (gen_st_r == ST_DLY1) ? dly1_per : dly2_per;
    wire       dly_tick  = unit_per ? per_tick : base_tick;
    wire       dly_done  = dly_tick & (dly_cnt_r <= 16'h0001);
    wire [CNT_W-1:0] ui_reload = (ui_r <= 24'h000001) ? '0 : ui_r - 24'h000001;

    always_comb begin
        gen_nxt = gen_st_r;
        case (gen_st_r)
            ST_IDLE: begin
                if (start_ok)
                    gen_nxt = use_dly1 ? ST_DLY1 : ST_RUN;
            end
            ST_DLY1: begin
                if (dly_done)
                    gen_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (wave_end) begin
                    if (halt_wave)
                        gen_nxt = ST_IDLE;
                    else if (dly2_r != '0)
                        gen_nxt = ST_DLY2;
                end
            end
            ST_DLY2: begin
                if (dly_done)
                    gen_nxt = ST_RUN;
            end
            default: gen_nxt = ST_IDLE;
        endcase
        if (halt_now || cmd_clear)
            gen_nxt = ST_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gen_st_r    <= ST_IDLE;
            armed_r     <= 1'b0;
            stop_pend_r <= 1'b0;
            run_ch_r    <= 2'h0;
        end else begin
            gen_st_r    <= gen_nxt;
            armed_r     <= cmd_arm
                         | (armed_r & ~cmd_stop & ~cmd_clear
                            & ~(start_ok & ~retrig));
            stop_pend_r <= (gen_nxt != ST_IDLE) & (stop_pend_r | cmd_stop);
            if (start_ok)
                run_ch_r <= timed;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || !active || (gen_nxt == ST_RUN && gen_st_r != ST_RUN))
            ui_cnt_r <= '0;
        else if (base_tick)
            ui_cnt_r <= (ui_cnt_r == '0) ? ui_reload : ui_cnt_r - 24'h000001;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || !active) begin
            uc_cnt_r <= '0;
            it_cnt_r <= '0;
        end else if (wave_end) begin
            uc_cnt_r <= '0;
            it_cnt_r <= group_end ? '0 : it_cnt_r + 24'h000001;
        end else if (upd_tick) begin
            uc_cnt_r <= uc_cnt_r + 24'h000001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            dly_cnt_r <= '0;
        else if (gen_st_r == ST_IDLE && gen_nxt == ST_DLY1)
            dly_cnt_r <= dly1_r;
        else if (gen_st_r == ST_RUN && gen_nxt == ST_DLY2)
            dly_cnt_r <= dly2_r;
        else if (dly_tick && dly_cnt_r != '0
                 && (gen_st_r == ST_DLY1 || gen_st_r == ST_DLY2))
            dly_cnt_r <= dly_cnt_r - 16'h0001;
    end

    // Sample FIFO, shared by the timed channels
    logic [CODE_W-1:0] fifo_mem [FIFO_DEPTH];
    wire  [25:0] wave_words = (n_ch == 2'h2) ? {1'b0, uc_r, 1'b0}
                                             : {2'h0, uc_r};
    wire  fits  = wave_words <= 26'(FIFO_DEPTH);
    wire  push  = wr_go & sel_fifo;
    wire  pop_n = upd_tick & have_data & ~replay_r;
    wire  [AW:0] pop_cnt = pop_n ? {{(AW-1){1'b0}}, n_ch} : '0;
    wire  [AW:0] push_cnt = push ? (AW+1)'(1) : '0;
    wire  [CODE_W-1:0] word0 = fifo_mem[rd_ptr_r];
    wire  [CODE_W-1:0] word1 = fifo_mem[rd_ptr_r + AW'(1)];
    assign fifo_full      = level_r == (AW+1)'(FIFO_DEPTH);
    assign dma_refill_req = active & ~replay_r & ~fifo_full;

    always_ff @(posedge sys_clk) begin
        if (push)
            fifo_mem[wr_ptr_r] <= wd[CODE_W-1:0];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || cmd_clear) begin
            wr_ptr_r   <= '0;
            rd_ptr_r   <= '0;
            base_ptr_r <= '0;
            level_r    <= '0;
            replay_r   <= 1'b0;
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + AW'(1);
            level_r <= level_r + push_cnt - pop_cnt;
            if (start_ok) begin
                base_ptr_r <= rd_ptr_r;
                replay_r   <= fits;
            end
            if (wave_end && replay_r)
                rd_ptr_r <= base_ptr_r;
            else if (upd_tick && have_data)
                rd_ptr_r <= rd_ptr_r + AW'(n_ch);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            underrun_r <= 1'b0;
        else
            underrun_r <= (upd_tick & ~have_data) | (underrun_r & ~cmd_clear);
    end

    // Channel output stages
    logic [CODE_W-1:0] code_r [NUM_CH];
    logic              strobe_r [NUM_CH];
    wire  [1:0]        sw_sel = {sel_sw1, sel_sw0};

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        wire [CODE_W-1:0] t_word = (ch == 1 && run_ch_r[0]) ? word1 : word0;
        wire load_t = upd_tick & have_data & run_ch_r[ch];
        wire load_s = wr_go & sw_sel[ch] & ~timed[ch];
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                code_r[ch]   <= CODE_W'(CODE_RST);
                strobe_r[ch] <= 1'b0;
            end else begin
                if (load_t)
                    code_r[ch] <= t_word;
                else if (load_s)
                    code_r[ch] <= CODE_W'(merge_be(32'(code_r[ch]), wd,
                                                   avs_byteenable));
                strobe_r[ch] <= load_t | load_s;
            end
        end
    end

    assign dac_code0           = code_r[0];
    assign dac_code1           = code_r[1];
    assign output_write_strobe = {strobe_r[1], strobe_r[0]};
    assign dac_busy            = {2{active}} & run_ch_r;

    // Read-back
    wire [31:0] status = (32'(level_r) << S_LEVEL)
                       | (32'(armed_r) << S_ARMED)
                       | (32'(underrun_r) << S_UNDER)
                       | (32'(fifo_full) << S_FULL)
                       | (32'(level_r == '0) << S_EMPTY)
                       | (32'(dac_busy) << S_BUSY);
    wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_r)
                       : sel_stat ? status
                       : sel_ui   ? 32'(ui_r)
                       : sel_uc   ? 32'(uc_r)
                       : sel_ic   ? 32'(ic_r)
                       : sel_dly1 ? 32'(dly1_r)
                       : sel_dly2 ? 32'(dly2_r)
                       : sel_sw0  ? 32'(code_r[0])
                       : sel_sw1  ? 32'(code_r[1])
                       : 32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_ack_r   <= 1'b0;
            readdata_r <= 32'h00000000;
        end else begin
            rd_ack_r <= avs_read & ~rd_ack_r;
            if (avs_read && !rd_ack_r)
                readdata_r <= rd_mux;
        end
    end

    // Checks
    default clocking dws_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_post_trig_run: assert property (
        start_ok && !use_dly1 && !cmd_clear |=> gen_st_r == ST_RUN)
        else $error("post-trigger did not start at once");
    a_delay_trig_load: assert property (
        start_ok && use_dly1 && !cmd_clear
        |=> gen_st_r == ST_DLY1 && dly_cnt_r == $past(dly1_r))
        else $error("delay-trigger did not load first delay");
    a_dly_count_down: assert property (
        gen_st_r == ST_DLY1 && dly_tick && dly_cnt_r > 16'h0001
        && !halt_now && !cmd_clear
        |=> gen_st_r == ST_DLY1 && dly_cnt_r == $past(dly_cnt_r) - 16'h0001)
        else $error("first delay did not count down");
    a_timed_strobe: assert property (
        upd_tick && have_data && run_ch_r[0]
        |=> output_write_strobe[0] && dac_code0 == $past(word0))
        else $error("timed update not strobed with sample");
    a_sw_apply: assert property (
        wr_go && sel_sw0 && !timed[0] && avs_byteenable == 4'hF
        |=> dac_code0 == $past(avs_writedata[CODE_W-1:0])
            && output_write_strobe[0])
        else $error("software code not applied");
    a_stop_now: assert property (
        cmd_stop && active && stop_mode == STOP_NOW
        |=> gen_st_r == ST_IDLE && !dac_busy[0] && !dac_busy[1])
        else $error("stop mode one did not halt");
    a_retrig_ignore: assert property (
        gen_st_r == ST_RUN && trig_any && !wave_end && !halt_now && !cmd_clear
        |=> gen_st_r == ST_RUN && uc_cnt_r >= $past(uc_cnt_r))
        else $error("trigger disturbed running waveform");
    a_infinite_keep: assert property (
        wave_end && infinite && !stop_req && !cmd_clear
        |=> gen_st_r != ST_IDLE)
        else $error("infinite generation ended without stop");
    a_replay_rewind: assert property (
        wave_end && replay_r && !cmd_clear |=> rd_ptr_r == $past(base_ptr_r))
        else $error("replay did not rewind read pointer");
    a_busy_start: assert property (
        start_ok && !cmd_clear |=> dac_busy == $past(timed))
        else $error("busy not raised at start");

    c_retrigger: cover property (start_ok && retrig && uc_cnt_r == '0);
    c_stop_iter: cover property (
        wave_end && halt_wave && stop_req && stop_mode == STOP_ITER);
    c_dly2_gap: cover property (gen_st_r == ST_DLY2 ##1 gen_st_r == ST_RUN);
    c_stream: cover property (pop_n && dma_refill_req);

endmodule : dws_top

// [dv/dws_dac_model.sv]
// Behavioural model of the two converter channels
`timescale 1ns/1ps
module dws_dac_model (
    input wire logic        sys_clk,
    input wire logic [11:0] code0,
    input wire logic [11:0] code1,
    input wire logic [1:0]  strobe,
    input wire logic [1:0]  bipolar
);
    int          upd_cnt [2];
    int          level   [2];
    int          gap     [2];
    int          last_t  [2];
    int          cyc;
    logic [11:0] held    [2];

    // Latch the code of a channel on each strobe pulse
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        for (int c = 0; c < 2; c++) begin
            if (strobe[c] === 1'b1) begin
                held[c] = c ? code1 : code0;
                level[c] = bipolar[c] ? int'(held[c]) - 2048
                                      : int'(held[c]);
                upd_cnt[c] = upd_cnt[c] + 1;
                gap[c] = cyc - last_t[c];
                last_t[c] = cyc;
            end
        end
    end
endmodule : dws_dac_model

// [dv/testbench.sv]
// Self-checking bench for the two-channel waveform sequencer
`timescale 1ns/1ps
module testbench;
    import dws_pkg::*;
    typedef struct {logic wr; logic [5:0] a; logic [31:0] d;} dws_row_s;

    logic        sys_clk         = 1'b0;
    logic        rst_b           = 1'b0;
    logic [5:0]  avs_address     = 6'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic        trigger_in      = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] dac_code0;
    logic [11:0] dac_code1;
    logic [1:0]  strobe;
    logic [1:0]  dac_bipolar;
    logic [1:0]  dac_busy;
    logic        dma_refill_req;
    int          num_errors;
    int          comparisons;
    int          n;
    dws_row_s    rows [15] = '{
        '{1'b0, OFS_CTRL, 32'h0}, '{1'b0, OFS_UI, 32'h28},
        '{1'b0, OFS_UC, 32'h1}, '{1'b0, OFS_IC, 32'h1},
        '{1'b0, OFS_DLY1, 32'h0}, '{1'b0, OFS_DLY2, 32'h0},
        '{1'b0, OFS_STATUS, 32'h4}, '{1'b0, OFS_CMD, 32'h0},
        '{1'b0, 6'h2C, 32'h0}, '{1'b1, 6'h2C, 32'hFFFF},
        '{1'b0, 6'h2C, 32'h0}, '{1'b1, OFS_DLY2, 32'hABCD1234},
        '{1'b0, OFS_DLY2, 32'h1234}, '{1'b1, OFS_UC, 32'hFF123456},
        '{1'b0, OFS_UC, 32'h123456}};

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    dws_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in),
        .dac_code0(dac_code0), .dac_code1(dac_code1),
        .output_write_strobe(strobe), .dac_bipolar(dac_bipolar),
        .external_reference_input(), .dac_busy(dac_busy),
        .dma_refill_req(dma_refill_req));

    dws_dac_model dac_u (.sys_clk(sys_clk), .code0(dac_code0),
        .code1(dac_code1), .strobe(strobe), .bipolar(dac_bipolar));

    task automatic finish_test;
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic fail(input string m);
        num_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) fail($sformatf("got %h expected %h", g, e));
    endtask : chk

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        for (i = 0; i < 50; i++) begin
            @(negedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            fail("bus hang");
            finish_test();
        end
        @(posedge sys_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    task automatic wait_busy(input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge sys_clk);
            if (dac_busy[1] === v) break;
        end
        if (i == lim) begin
            fail("busy wait");
            finish_test();
        end
    endtask : wait_busy

    task automatic pulse;
        @(posedge sys_clk);
        trigger_in <= 1'b1;
        @(posedge sys_clk);
        trigger_in <= 1'b0;
    endtask : pulse

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        chk({dac_busy, strobe, dac_code1, dac_code0}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else rd(rows[i].a, rows[i].d);
        end
        // Three words replayed twice on channel 1
        wr(OFS_UI, 32'h28);
        wr(OFS_DLY2, 32'h0);
        wr(OFS_UC, 32'h3);
        wr(OFS_IC, 32'h2);
        wr(OFS_FIFO, 32'h800);
        wr(OFS_FIFO, 32'hFFF);
        wr(OFS_FIFO, 32'h001);
        wr(OFS_CTRL, 32'h00A);
        wr(OFS_SW0, 32'h5A5);
        @(negedge sys_clk);
        chk({dac_bipolar, dac_code0}, 32'h25A5);
        wr(OFS_CMD, 32'h1);
        repeat (20) @(posedge sys_clk);
        chk(dac_busy, 32'h0);
        pulse();
        wait_busy(1'b1, 5);
        chk(dma_refill_req, 32'h0);
        wait_busy(1'b0, 2000);
        repeat (2) @(negedge sys_clk);
        chk(dac_u.upd_cnt[1], 6);
        chk(dac_u.level[1], -2047);
        chk(dac_u.gap[1], 100);
        // Infinite run cut short by an immediate stop
        wr(OFS_CTRL, 32'h902);
        wr(OFS_CMD, 32'h1);
        wr(OFS_CMD, 32'h2);
        wait_busy(1'b1, 5);
        repeat (900) @(posedge sys_clk);
        chk(dac_busy[1], 32'h1);
        wr(OFS_CMD, 32'h4);
        wait_busy(1'b0, 5);
        repeat (2) @(negedge sys_clk);
        n = dac_u.upd_cnt[1];
        repeat (300) @(posedge sys_clk);
        chk(dac_u.upd_cnt[1], n);
        // Delayed start, ignored retrigger, stop at waveform end
        wr(OFS_DLY1, 32'h000000C8);
        wr(OFS_CTRL, 32'h11C2);
        wr(OFS_CMD, 32'h1);
        pulse();
        n = dac_u.upd_cnt[1];
        repeat (450) @(posedge sys_clk);
        chk(dac_u.upd_cnt[1], n);
        pulse();
        repeat (300) @(posedge sys_clk);
        chk(dac_u.upd_cnt[1], n + 3);
        wr(OFS_CMD, 32'h4);
        wait_busy(1'b0, 1000);
        repeat (2) @(negedge sys_clk);
        chk((dac_u.upd_cnt[1] - n) % 3, 0);
        // Streaming run larger than the FIFO, ending in underrun
        wr(OFS_CMD, 32'h8);
        rd(OFS_STATUS, 32'h4);
        wr(OFS_UC, 32'h800);
        wr(OFS_CTRL, 32'h802);
        wr(OFS_FIFO, 32'h123);
        wr(OFS_FIFO, 32'h456);
        wr(OFS_CMD, 32'h1);
        wr(OFS_CMD, 32'h2);
        wait_busy(1'b1, 5);
        chk(dma_refill_req, 32'h1);
        repeat (350) @(negedge sys_clk);
        rd(OFS_STATUS, 32'h16);
        chk(dac_code1, 32'h456);
        wr(OFS_CMD, 32'hC);
        rd(OFS_STATUS, 32'h4);
        finish_test();
    end
endmodule : testbench
